// File: core/pfs_pkg.sv
// Purpose: shared constants for the upper port pin function select
// Assumes: 32-bit apb, word-aligned registers
// Notes: mode field positions and reset codes live here
package pfs_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PFS_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PFS_DIR_OFFSET = 8'h04;
  localparam logic [7:0] PFS_DOUT_OFFSET = 8'h08;
  localparam logic [7:0] PFS_PIN_OFFSET = 8'h0c;
  // ------------------------------------------------------------
  // field positions (low bit of each two-bit field)
  // ------------------------------------------------------------
  localparam int PFS_P13_LSB = 10;
  localparam int PFS_P12_LSB = 8;
  localparam int PFS_P11_LSB = 6;
  localparam int PFS_P10_LSB = 4;
  localparam int PFS_P9_LSB = 2;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PFS_CTRL_RESET = 16'h0300;
  localparam logic [4:0] PFS_DIR_RESET = 5'h00;
  localparam logic [4:0] PFS_DOUT_RESET = 5'h00;
  // ------------------------------------------------------------
  // mode codes
  // ------------------------------------------------------------
  localparam logic [1:0] PFS_MODE_GPIO = 2'h0;
  localparam logic [1:0] PFS_MODE_ALT1 = 2'h1;
  localparam logic [1:0] PFS_MODE_ALT2 = 2'h2;
  localparam logic [1:0] PFS_MODE_ALT3 = 2'h3;
endpackage

// File: core/pfs_pin_cell.sv
// Purpose: one pin's output mux and enable
// Assumes: per-code output data and drive enables supplied by caller
// Notes: code selects one of four functions
`timescale 1ns/1ps
module pfs_pin_cell (
  input wire logic [1:0] mode_i,
  input wire logic [3:0] func_out_i,
  input wire logic [3:0] func_oe_i,
  output logic pin_o,
  output logic pin_oe_o
);
  // ------------------------------------------------------------
  // function select
  // ------------------------------------------------------------
  always_comb begin
    pin_o = func_out_i[mode_i];
    pin_oe_o = func_oe_i[mode_i];
  end
endmodule

// File: core/pfs_top.sv
// Purpose: function select for port pins 13 down to 9
// Assumes: apb slave, single clock, pins as in/out/oe triples
// Notes: reserved codes leave the pin released as input
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Contract
// [RULE_01] pin13 code 01 is irq channel 1 input
// [RULE_02] pin13 code 10 is timer clock b
// [RULE_03] pin13 code 11 is dma request 0
// [RULE_04] pin12 field bits 9:8, 00 gpio
// [RULE_05] pin12 code 01 is irq channel 0 input
// [RULE_06] pin12 code 11 drives dma ack; reset
// [RULE_07] pin11 field bits 7:6 decoded
// [RULE_08] pin11 code 01 is upper bus parity
// [RULE_09] pin11 code 10 timer capcomp b; 11 reserved
// [RULE_10] pin10 field bits 5:4, reset 00 gpio
// [RULE_11] pin10 code 01 is lower bus parity
// [RULE_12] pin9 field bits 3:2, reset 00 gpio
// [RULE_13] pin9 code 01 drives address hold strobe
// [RULE_14] pin9 code 11 drives irq request out
// [RULE_15] pin13 field bits 11:10, reset 00 gpio
// [RULE_16] pin11 code 00 reset gpio
// [RULE_17] pin10 code 10 timer capcomp a; 11 reserved
// [RULE_18] pin9 code 10 is adc start trigger
// [RULE_19] software avoids reserved codes; pin stays input
// [RULE_20] enable follows function direction
module pfs_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_pin_13_i,
  output logic port_pin_13_o,
  output logic port_pin_13_oe_o,
  input wire logic port_pin_12_i,
  output logic port_pin_12_o,
  output logic port_pin_12_oe_o,
  input wire logic port_pin_11_i,
  output logic port_pin_11_o,
  output logic port_pin_11_oe_o,
  input wire logic port_pin_10_i,
  output logic port_pin_10_o,
  output logic port_pin_10_oe_o,
  input wire logic port_pin_9_i,
  output logic port_pin_9_o,
  output logic port_pin_9_oe_o,
  output logic ext_irq_in_ch1_o,
  output logic ext_irq_in_ch0_o,
  output logic timer_ext_clock_b_o,
  output logic dma_request_ch0_o,
  input wire logic dma_acknowledge_ch0_i,
  input wire logic upper_bus_parity_i,
  input wire logic upper_bus_parity_oe_i,
  output logic upper_bus_parity_o,
  input wire logic lower_bus_parity_i,
  input wire logic lower_bus_parity_oe_i,
  output logic lower_bus_parity_o,
  input wire logic timer_capcomp_b_i,
  input wire logic timer_capcomp_b_oe_i,
  output logic timer_capcomp_b_o,
  input wire logic timer_capcomp_a_i,
  input wire logic timer_capcomp_a_oe_i,
  output logic timer_capcomp_a_o,
  input wire logic address_hold_strobe_i,
  output logic adc_start_trigger_o,
  input wire logic irq_request_out_i
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [4:0] dir_q;
  logic [4:0] dout_q;
  logic [31:0] rdata_d;
  logic wr_en;
  logic wr_ctrl;
  logic wr_dir;
  logic wr_dout;
  logic hit;
  logic [3:0] p13_fout;
  logic [3:0] p13_foe;
  logic [3:0] p12_fout;
  logic [3:0] p12_foe;
  logic [3:0] p11_fout;
  logic [3:0] p11_foe;
  logic [3:0] p10_fout;
  logic [3:0] p10_foe;
  logic [3:0] p9_fout;
  logic [3:0] p9_foe;
  logic [1:0] m13;
  logic [1:0] m12;
  logic [1:0] m11;
  logic [1:0] m10;
  logic [1:0] m9;
  logic [4:0] pin_in;

  assign m13 = ctrl_q[pfs_pkg::PFS_P13_LSB +: 2]; // [RULE_15]
  assign m12 = ctrl_q[pfs_pkg::PFS_P12_LSB +: 2]; // [RULE_04]
  assign m11 = ctrl_q[pfs_pkg::PFS_P11_LSB +: 2]; // [RULE_07]
  assign m10 = ctrl_q[pfs_pkg::PFS_P10_LSB +: 2]; // [RULE_10]
  assign m9 = ctrl_q[pfs_pkg::PFS_P9_LSB +: 2]; // [RULE_12]
  assign pin_in = {port_pin_13_i, port_pin_12_i, port_pin_11_i, port_pin_10_i, port_pin_9_i};

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign wr_ctrl = wr_en && (paddr == pfs_pkg::PFS_CTRL_OFFSET);
  assign wr_dir = wr_en && (paddr == pfs_pkg::PFS_DIR_OFFSET);
  assign wr_dout = wr_en && (paddr == pfs_pkg::PFS_DOUT_OFFSET);
  always_comb begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      pfs_pkg::PFS_CTRL_OFFSET: rdata_d = {16'h0000, ctrl_q};
      pfs_pkg::PFS_DIR_OFFSET: rdata_d = {27'h000_0000, dir_q};
      pfs_pkg::PFS_DOUT_OFFSET: rdata_d = {27'h000_0000, dout_q};
      pfs_pkg::PFS_PIN_OFFSET: rdata_d = {27'h000_0000, pin_in};
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_d;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= pfs_pkg::PFS_CTRL_RESET; // [RULE_06] [RULE_10] [RULE_16]
    end else if (wr_ctrl) begin
      ctrl_q <= {4'h0, pwdata[11:2], 2'h0};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_q <= pfs_pkg::PFS_DIR_RESET;
    end else if (wr_dir) begin
      dir_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dout_q <= pfs_pkg::PFS_DOUT_RESET;
    end else if (wr_dout) begin
      dout_q <= pwdata[4:0];
    end
  end

  // ------------------------------------------------------------
  // inbound routing, pin 13
  // ------------------------------------------------------------
  always_comb begin
    ext_irq_in_ch1_o = 1'b0;
    timer_ext_clock_b_o = 1'b0;
    dma_request_ch0_o = 1'b0;
    unique case (m13)
      pfs_pkg::PFS_MODE_GPIO: begin
        ext_irq_in_ch1_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT1: begin
        ext_irq_in_ch1_o = port_pin_13_i; // [RULE_01]
      end
      pfs_pkg::PFS_MODE_ALT2: begin
        timer_ext_clock_b_o = port_pin_13_i; // [RULE_02]
      end
      pfs_pkg::PFS_MODE_ALT3: begin
        dma_request_ch0_o = port_pin_13_i; // [RULE_03]
      end
    endcase
  end

  // ------------------------------------------------------------
  // inbound routing, pin 12
  // ------------------------------------------------------------
  always_comb begin
    ext_irq_in_ch0_o = 1'b0;
    unique case (m12)
      pfs_pkg::PFS_MODE_GPIO: begin
        ext_irq_in_ch0_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT1: begin
        ext_irq_in_ch0_o = port_pin_12_i; // [RULE_05]
      end
      pfs_pkg::PFS_MODE_ALT2: begin
        ext_irq_in_ch0_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT3: begin
        ext_irq_in_ch0_o = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // inbound routing, pin 11
  // ------------------------------------------------------------
  always_comb begin
    upper_bus_parity_o = 1'b0;
    timer_capcomp_b_o = 1'b0;
    unique case (m11)
      pfs_pkg::PFS_MODE_GPIO: begin
        upper_bus_parity_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT1: begin
        upper_bus_parity_o = port_pin_11_i; // [RULE_08]
      end
      pfs_pkg::PFS_MODE_ALT2: begin
        timer_capcomp_b_o = port_pin_11_i; // [RULE_09]
      end
      pfs_pkg::PFS_MODE_ALT3: begin
        upper_bus_parity_o = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // inbound routing, pin 10
  // ------------------------------------------------------------
  always_comb begin
    lower_bus_parity_o = 1'b0;
    timer_capcomp_a_o = 1'b0;
    unique case (m10)
      pfs_pkg::PFS_MODE_GPIO: begin
        lower_bus_parity_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT1: begin
        lower_bus_parity_o = port_pin_10_i; // [RULE_11]
      end
      pfs_pkg::PFS_MODE_ALT2: begin
        timer_capcomp_a_o = port_pin_10_i; // [RULE_17]
      end
      pfs_pkg::PFS_MODE_ALT3: begin
        lower_bus_parity_o = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // inbound routing, pin 9
  // ------------------------------------------------------------
  always_comb begin
    adc_start_trigger_o = 1'b0;
    unique case (m9)
      pfs_pkg::PFS_MODE_GPIO: begin
        adc_start_trigger_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT1: begin
        adc_start_trigger_o = 1'b0;
      end
      pfs_pkg::PFS_MODE_ALT2: begin
        adc_start_trigger_o = port_pin_9_i; // [RULE_18]
      end
      pfs_pkg::PFS_MODE_ALT3: begin
        adc_start_trigger_o = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // per-pin function vectors: {code11, code10, code01, code00}
  // ------------------------------------------------------------
  assign p13_fout = {1'b0, 1'b0, 1'b0, dout_q[4]};
  assign p13_foe = {1'b0, 1'b0, 1'b0, dir_q[4]}; // [RULE_20]
  assign p12_fout = {dma_acknowledge_ch0_i, 1'b0, 1'b0, dout_q[3]}; // [RULE_06]
  assign p12_foe = {1'b1, 1'b0, 1'b0, dir_q[3]}; // [RULE_20]
  assign p11_fout = {1'b0, timer_capcomp_b_i, upper_bus_parity_i, dout_q[2]}; // [RULE_08]
  assign p11_foe = {1'b0, timer_capcomp_b_oe_i, upper_bus_parity_oe_i, dir_q[2]}; // [RULE_09]
  assign p10_fout = {1'b0, timer_capcomp_a_i, lower_bus_parity_i, dout_q[1]}; // [RULE_11]
  assign p10_foe = {1'b0, timer_capcomp_a_oe_i, lower_bus_parity_oe_i, dir_q[1]}; // [RULE_17]
  assign p9_fout = {irq_request_out_i, 1'b0, address_hold_strobe_i, dout_q[0]}; // [RULE_13] [RULE_14]
  assign p9_foe = {1'b1, 1'b0, 1'b1, dir_q[0]}; // [RULE_20]

  // ------------------------------------------------------------
  // outbound pin cells: {code11, code10, code01, code00}
  // ------------------------------------------------------------
  pfs_pin_cell u_p13 (
    .mode_i(m13),
    .func_out_i(p13_fout),
    .func_oe_i(p13_foe),
    .pin_o(port_pin_13_o),
    .pin_oe_o(port_pin_13_oe_o)
  );
  pfs_pin_cell u_p12 (
    .mode_i(m12),
    .func_out_i(p12_fout),
    .func_oe_i(p12_foe),
    .pin_o(port_pin_12_o),
    .pin_oe_o(port_pin_12_oe_o)
  );
  pfs_pin_cell u_p11 (
    .mode_i(m11),
    .func_out_i(p11_fout),
    .func_oe_i(p11_foe),
    .pin_o(port_pin_11_o),
    .pin_oe_o(port_pin_11_oe_o)
  );
  pfs_pin_cell u_p10 (
    .mode_i(m10),
    .func_out_i(p10_fout),
    .func_oe_i(p10_foe),
    .pin_o(port_pin_10_o),
    .pin_oe_o(port_pin_10_oe_o)
  );
  pfs_pin_cell u_p9 (
    .mode_i(m9),
    .func_out_i(p9_fout),
    .func_oe_i(p9_foe),
    .pin_o(port_pin_9_o),
    .pin_oe_o(port_pin_9_oe_o)
  );
endmodule

// File: testbench/pfs_pin_partner.sv
// Purpose: far-side pin model for pins 13 down to 9
// Assumes: no pulls on the pins
// Notes: bit 4 is pin 13, bit 0 is pin 9
`timescale 1ns/1ps
module pfs_pin_partner (
  input wire logic [4:0] drv_i,
  input wire logic [4:0] oe_i,
  input wire logic [4:0] ext_i,
  output logic [4:0] lvl_o
);
  // block drive wins, released pins show the outside level
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// File: testbench/pfs_chk.sv
// Purpose: port checks for the pin function select
// Assumes: ctrl shadowed from apb writes
// Notes: bound into pfs_top
`timescale 1ns/1ps
module pfs_chk (
  input wire logic clk_i, sys_rst_i, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic port_pin_13_i, ext_irq_in_ch1_o, timer_ext_clock_b_o, dma_request_ch0_o,
  input wire logic port_pin_12_i, port_pin_12_o, port_pin_12_oe_o, ext_irq_in_ch0_o,
  input wire logic dma_acknowledge_ch0_i, port_pin_11_i, upper_bus_parity_o,
  input wire logic port_pin_9_o, port_pin_9_oe_o, address_hold_strobe_i, irq_request_out_i
);
  logic [11:0] c_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      c_q <= pfs_pkg::PFS_CTRL_RESET[11:0];
    end else if (psel && penable && pwrite && paddr == 8'h00) begin
      c_q <= pwdata[11:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_ext_irq_in_ch1_route: assert property (c_q[11:10] == 2'h1 |-> ext_irq_in_ch1_o == port_pin_13_i)
    else $error("ext_irq_in_ch1 route");
  a_tclk_route: assert property (c_q[11:10] == 2'h2 |-> timer_ext_clock_b_o == port_pin_13_i)
    else $error("timer clock route");
  a_dreq_route: assert property (c_q[11:10] == 2'h3 |-> dma_request_ch0_o == port_pin_13_i)
    else $error("dma request route");
  a_ext_irq_in_ch0_route: assert property (c_q[9:8] == 2'h1 |-> ext_irq_in_ch0_o == port_pin_12_i)
    else $error("ext_irq_in_ch0 route");
  a_dack_drive: assert property (c_q[9:8] == 2'h3 |-> port_pin_12_oe_o && port_pin_12_o == dma_acknowledge_ch0_i)
    else $error("dma ack drive");
  a_dph_route: assert property (c_q[7:6] == 2'h1 |-> upper_bus_parity_o == port_pin_11_i)
    else $error("upper parity route");
  a_ah_drive: assert property (c_q[3:2] == 2'h1 |-> port_pin_9_oe_o && port_pin_9_o == address_hold_strobe_i)
    else $error("address hold drive");
  a_irqo_drive: assert property (c_q[3:2] == 2'h3 |-> port_pin_9_oe_o && port_pin_9_o == irq_request_out_i)
    else $error("irq out drive");
  cover property (c_q[11:10] == 2'h3);
  cover property (c_q[3:2] == 2'h3);
  cover property (c_q[7:6] == 2'h1);
endmodule
bind pfs_top pfs_chk u_chk (.*);

// File: testbench/tb_port_a_upper_pin_function_select.sv
// Purpose: self-checking bench for the pin function select
// Assumes: zero-wait apb slave
// Notes: pin levels come from the far-side model
`timescale 1ns/1ps
module tb_port_a_upper_pin_function_select;
  logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [4:0] ext = 5'h00;
  logic pready, pslverr, ext_irq_in_ch1_o, ext_irq_in_ch0_o, timer_ext_clock_b_o, dma_request_ch0_o;
  logic upper_bus_parity_o, lower_bus_parity_o, timer_capcomp_b_o, timer_capcomp_a_o;
  logic adc_start_trigger_o, port_pin_13_o, port_pin_12_o, port_pin_11_o, port_pin_10_o;
  logic port_pin_9_o, port_pin_13_oe_o, port_pin_12_oe_o, port_pin_11_oe_o, port_pin_10_oe_o;
  logic port_pin_9_oe_o, dma_acknowledge_ch0_i = 0, upper_bus_parity_i = 0;
  logic upper_bus_parity_oe_i = 0, lower_bus_parity_i = 0, lower_bus_parity_oe_i = 0;
  logic timer_capcomp_b_i = 0, timer_capcomp_b_oe_i = 0, timer_capcomp_a_i = 0;
  logic timer_capcomp_a_oe_i = 0, address_hold_strobe_i = 0, irq_request_out_i = 0;
  wire logic port_pin_13_i, port_pin_12_i, port_pin_11_i, port_pin_10_i, port_pin_9_i;
  wire logic [4:0] po = {port_pin_13_o, port_pin_12_o, port_pin_11_o, port_pin_10_o, port_pin_9_o};
  wire logic [4:0] pe = {port_pin_13_oe_o, port_pin_12_oe_o, port_pin_11_oe_o,
                         port_pin_10_oe_o, port_pin_9_oe_o};
  int fail_count = 0, n_tests = 0;
  always #20 clk_i = ~clk_i;
  pfs_top u_dut (.*);
  pfs_pin_partner u_far (.drv_i(po), .oe_i(pe), .ext_i(ext),
    .lvl_o({port_pin_13_i, port_pin_12_i, port_pin_11_i, port_pin_10_i, port_pin_9_i}));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end else begin
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic s_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h300);
    dma_acknowledge_ch0_i <= 1'b1;
    tick();
    chk({pe, port_pin_12_o}, 6'h11);
  endtask
  task automatic s_inputs;
    apb(1'b1, 8'h00, 32'h568);
    ext <= 5'h15;
    tick();
    chk({ext_irq_in_ch1_o, ext_irq_in_ch0_o, upper_bus_parity_o, timer_capcomp_a_o,
         adc_start_trigger_o, timer_ext_clock_b_o, pe}, 11'h540);
    apb(1'b1, 8'h00, 32'h890);
    tick();
    chk({timer_ext_clock_b_o, timer_capcomp_b_o, lower_bus_parity_o}, 3'h6);
    apb(1'b1, 8'h00, 32'hc00);
    tick();
    chk({dma_request_ch0_o, timer_ext_clock_b_o, ext_irq_in_ch1_o}, 3'h4);
  endtask
  task automatic s_outputs;
    {dma_acknowledge_ch0_i, address_hold_strobe_i} <= 2'b01;
    {upper_bus_parity_i, upper_bus_parity_oe_i} <= 2'b11;
    apb(1'b1, 8'h00, 32'h344);
    tick();
    chk({pe[2], po[2], pe[0], po[0], pe[3], po[3]}, 6'h3e);
    {irq_request_out_i, address_hold_strobe_i} <= 2'b10;
    apb(1'b1, 8'h00, 32'h30c);
    tick();
    chk({pe[0], po[0]}, 2'h3);
  endtask
  task automatic s_reserved;
    {timer_capcomp_a_oe_i, timer_capcomp_b_oe_i, lower_bus_parity_oe_i} <= 3'h7;
    {timer_capcomp_a_i, timer_capcomp_b_i, lower_bus_parity_i} <= 3'h7;
    apb(1'b1, 8'h00, 32'hf0);
    tick();
    chk({pe[2:1], po[2:1]}, 4'h0);
    chk({upper_bus_parity_o, lower_bus_parity_o, timer_capcomp_b_o, timer_capcomp_a_o}, 4'h0);
    apb(1'b1, 8'h00, 32'ha0);
    tick();
    chk({pe[2:1], po[2:1]}, 4'hf);
  endtask
  task automatic s_gpio;
    apb(1'b1, 8'h00, 32'hffff_feaf);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'heac);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h1f);
    apb(1'b1, 8'h08, 32'h15);
    tick();
    chk({pe, po}, 10'h3f5);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h15);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    s_reset();
    s_inputs();
    s_outputs();
    s_reserved();
    s_gpio();
    tally_and_finish();
  end
endmodule
